// file: verilog/srd_pkg.sv
/*
  constants, types and shared arithmetic of the spectroscopy readout datapath.
  assumes one 200 mhz sample clock; no software-visible registers.
*/
// Behaviour
// - one oscillator both generates and demodulates
// - continuous: oscillator to output and demodulator
// - pulsed: envelope times oscillator feeds both paths
// - envelopes up to 32/64 kSa; continuous envelope one
// - amplitude scaled by gain, range, envelope
// - oscillator phase reset restarts output phase
// - second oscillator down-converts: 1 GHz RF, 0 Hz LF
// - low-pass removes sum image before integration
// - multiply by conjugate reference, sum N, divide N
// - scope: root-two/C on RF, one/C on LF
// - result scaled by root-two/C before readout
// - LF path drops RF center frequency offset
`default_nettype none
package srd_pkg;
  localparam int    SMP_W       = 16;
  localparam int    PH_W        = 32;
  localparam int    RES_W       = 32;
  localparam longint CLK_HZ     = 200_000_000;
  localparam longint CLK_NS     = 5;
  // longest integration time and the sample count it allows
  localparam longint INT_MAX_NS = 16_700_000;
  localparam longint INT_MAX_CYC = INT_MAX_NS / CLK_NS;
  localparam int    N_W_DEF     = $clog2(INT_MAX_CYC + 1);
  // envelope address width: 32 kSa, or 64 kSa on the larger variant
  localparam int    ENV_AW_DEF  = 15;
  localparam int    ENV_AW_BIG  = 16;
  localparam int    FIFO_DEPTH  = 8;
  localparam int    LPF_TAPS    = 4;
  localparam int    LPF_SH      = 2;
  // second down-conversion oscillator frequencies
  localparam longint LO2_RF_HZ  = 1_000_000_000;
  localparam longint LO2_LF_HZ  = 0;
  localparam logic [PH_W-1:0] LO2_RF_WORD = PH_W'(((LO2_RF_HZ % CLK_HZ) << PH_W) / CLK_HZ);
  localparam logic [PH_W-1:0] LO2_LF_WORD = PH_W'(((LO2_LF_HZ % CLK_HZ) << PH_W) / CLK_HZ);
  // q1.15 unity and q4.12 scale factors
  localparam logic signed [SMP_W-1:0] ONE_Q15 = 16'sh7fff;
  localparam int    SCL_SH      = 12;
  localparam logic signed [SMP_W-1:0] SCL_RF = 16'sh16a1; // root two over scaling constant
  localparam logic signed [SMP_W-1:0] SCL_LF = 16'sh1000; // one over scaling constant
  localparam logic [PH_W-1:0] PH_RST    = 32'h0000_0000;
  localparam logic [5:0]      DIV_CNT_RST = 6'h00;

  typedef enum logic [3:0] {
    SRD_IDLE  = 4'b0001,
    SRD_INTEG = 4'b0010,
    SRD_DIV   = 4'b0100,
    SRD_PUSH  = 4'b1000
  } srd_state_t;

  // quarter-wave sine table, q1.15 magnitudes
  localparam logic [15:0] SIN_TAB [16] = '{
    16'h0647, 16'h12c8, 16'h1f1a, 16'h2b1f, 16'h36ba, 16'h41ce, 16'h4c3b, 16'h55f5,
    16'h5ed7, 16'h66cf, 16'h6dc9, 16'h73b5, 16'h7883, 16'h7c29, 16'h7e9c, 16'h7fd8};

  // sine of the top six phase bits
  function automatic logic signed [SMP_W-1:0] sin_f(input logic [5:0] p);
    logic [3:0]  k;
    logic [15:0] m;
    k = p[4] ? ~p[3:0] : p[3:0];
    m = SIN_TAB[k];
    return p[5] ? -$signed(m) : $signed(m);
  endfunction

  // q1.15 product of two samples
  function automatic logic signed [SMP_W-1:0] mul_q15(input logic signed [SMP_W-1:0] a,
                                                      input logic signed [SMP_W-1:0] b);
    logic signed [2*SMP_W-1:0] p;
    p = a * b;
    return p[2*SMP_W-2:SMP_W-1];
  endfunction

  // q4.12 scaling of a sample
  function automatic logic signed [SMP_W-1:0] scl_f(input logic signed [SMP_W-1:0] a,
                                                    input logic signed [SMP_W-1:0] s);
    logic signed [2*SMP_W-1:0] p;
    p = a * s;
    return p[SCL_SH+SMP_W-1:SCL_SH];
  endfunction
endpackage
`default_nettype wire

// file: verilog/srd_fifo.sv
/*
  result fifo: parameter width and depth, valid/ready on both sides.
  assumes the same clock, clock enable and synchronous reset as its user.
*/
`timescale 1ns/1ps
`default_nettype none
module srd_fifo #(
  parameter int W     = 64,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          wr;
  logic          rd;

  // output register empty or being drained pulls the next word
  assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
  assign wr         = in_valid_i && in_ready_o;
  assign rd         = (cnt_ff != '0) && (!out_valid_o || out_ready_i);

  // storage, pointers and the registered read side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_ff       <= '0;
      rp_ff       <= '0;
      cnt_ff      <= '0;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (ce_i) begin
      if (wr) begin
        mem[wp_ff] <= in_data_i;
        wp_ff      <= wp_ff + 1'b1;
      end
      if (rd) begin
        out_data_o <= mem[rp_ff];
        rp_ff      <= rp_ff + 1'b1;
      end
      if (rd) begin
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
      cnt_ff <= cnt_ff + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule
`default_nettype wire

// file: verilog/srd_top.sv
/*
  spectroscopy readout datapath: oscillator, envelope, dac feed, adc
  down-conversion, image filter, demodulation, normalised integration.
  assumes adc samples and envelope memory data on the same clock; the
  envelope memory answers one cycle after env_addr_o.
*/
`timescale 1ns/1ps
`default_nettype none
module srd_top #(
  parameter int ENV_AW = srd_pkg::ENV_AW_DEF,
  parameter int N_W    = srd_pkg::N_W_DEF
) (
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             ce_i,
  input  wire logic                             pulsed_i,
  input  wire logic                             path_lf_i,
  input  wire logic [srd_pkg::PH_W-1:0]         osc_freq_i,
  input  wire logic [srd_pkg::PH_W-1:0]         center_freq_i,
  input  wire logic                             phase_reset_i,
  input  wire logic signed [srd_pkg::SMP_W-1:0] osc_gain_i,
  input  wire logic signed [srd_pkg::SMP_W-1:0] out_range_i,
  input  wire logic [ENV_AW:0]                  env_len_i,
  input  wire logic [N_W-1:0]                   int_len_i,
  input  wire logic                             start_i,
  input  wire logic signed [srd_pkg::SMP_W-1:0] env_i_i,
  input  wire logic signed [srd_pkg::SMP_W-1:0] env_q_i,
  input  wire logic signed [srd_pkg::SMP_W-1:0] adc_i,
  input  wire logic                             res_ready_i,
  output logic [ENV_AW-1:0]                     env_addr_o,
  output logic signed [srd_pkg::SMP_W-1:0]      dac_i_o,
  output logic signed [srd_pkg::SMP_W-1:0]      dac_q_o,
  output logic [srd_pkg::PH_W-1:0]              out_freq_o,
  output logic signed [srd_pkg::SMP_W-1:0]      scope_i_o,
  output logic signed [srd_pkg::SMP_W-1:0]      scope_q_o,
  output logic                                  busy_o,
  output logic                                  res_valid_o,
  output logic [2*srd_pkg::RES_W-1:0]           res_data_o
);
  localparam int SW    = srd_pkg::SMP_W;
  localparam int ACC_W = 2*SW + N_W + 1; // full-scale products times max count
  localparam int LW    = SW + srd_pkg::LPF_SH;

  typedef struct packed {
    srd_pkg::srd_state_t           st;
    logic                          busy;
    logic [srd_pkg::PH_W-1:0]      ph;
    logic [srd_pkg::PH_W-1:0]      lo2_ph;
    logic [srd_pkg::PH_W-1:0]      fout;
    logic [ENV_AW:0]               env_cnt;
    logic                          pact;
    logic signed [SW-1:0]          ref_i;
    logic signed [SW-1:0]          ref_q;
    logic signed [SW-1:0]          dac_i;
    logic signed [SW-1:0]          dac_q;
    logic [srd_pkg::LPF_TAPS-1:0][SW-1:0] tap_i;
    logic [srd_pkg::LPF_TAPS-1:0][SW-1:0] tap_q;
    logic signed [SW-1:0]          bb_i;
    logic signed [SW-1:0]          bb_q;
    logic signed [SW-1:0]          scp_i;
    logic signed [SW-1:0]          scp_q;
    logic signed [ACC_W-1:0]       acc_i;
    logic signed [ACC_W-1:0]       acc_q;
    logic [N_W-1:0]                cnt;
    logic [N_W-1:0]                nlen;
    logic [ACC_W-1:0]              qt_i;
    logic [ACC_W-1:0]              qt_q;
    logic [N_W:0]                  rm_i;
    logic [N_W:0]                  rm_q;
    logic                          sg_i;
    logic                          sg_q;
    logic [5:0]                    dcnt;
    logic [2*srd_pkg::RES_W-1:0]   res;
  } srd_st_t;

  srd_st_t r_ff;
  srd_st_t nxt_r;
  logic    fifo_ready;

  // one restoring-division step: returns {remainder, quotient}
  function automatic logic [N_W+ACC_W:0] div_step(input logic [N_W:0]     rm,
                                                  input logic [ACC_W-1:0] qt,
                                                  input logic [N_W-1:0]   d);
    logic [N_W:0]     r;
    logic [ACC_W-1:0] q;
    r = {rm[N_W-1:0], qt[ACC_W-1]};
    q = {qt[ACC_W-2:0], 1'b0};
    if (r >= {1'b0, d}) begin
      r    = r - {1'b0, d};
      q[0] = 1'b1;
    end
    return {r, q};
  endfunction

  // magnitude of a signed accumulator
  function automatic logic [ACC_W-1:0] mag_f(input logic signed [ACC_W-1:0] a);
    return a[ACC_W-1] ? ACC_W'(-a) : ACC_W'(a);
  endfunction

  // signed normalised quotient scaled to rms input units
  function automatic logic [srd_pkg::RES_W-1:0] rms_f(input logic [ACC_W-1:0] q,
                                                      input logic             sg);
    logic signed [ACC_W:0]      sq;
    logic signed [ACC_W+SW:0]   p;
    sq = sg ? -$signed({1'b0, q}) : $signed({1'b0, q});
    p  = sq * srd_pkg::SCL_RF;
    return p[srd_pkg::SCL_SH+srd_pkg::RES_W-1:srd_pkg::SCL_SH];
  endfunction

  // next state of the whole datapath
  always_comb begin
    logic signed [SW-1:0]   osc_c;
    logic signed [SW-1:0]   osc_s;
    logic signed [SW-1:0]   lo_c;
    logic signed [SW-1:0]   lo_s;
    logic signed [SW-1:0]   en_i;
    logic signed [SW-1:0]   en_q;
    logic signed [SW-1:0]   amp;
    logic signed [SW-1:0]   mx_i;
    logic signed [SW-1:0]   mx_q;
    logic signed [LW-1:0]   sum_i;
    logic signed [LW-1:0]   sum_q;
    logic signed [2*SW:0]   pr_i;
    logic signed [2*SW:0]   pr_q;
    logic [N_W+ACC_W:0]     st_i;
    logic [N_W+ACC_W:0]     st_q;
    // every local gets a value first so that no path leaves one unassigned
    osc_c = '0;
    osc_s = '0;
    lo_c  = '0;
    lo_s  = '0;
    en_i  = '0;
    en_q  = '0;
    amp   = '0;
    mx_i  = '0;
    mx_q  = '0;
    sum_i = '0;
    sum_q = '0;
    pr_i  = '0;
    pr_q  = '0;
    st_i  = '0;
    st_q  = '0;

    nxt_r = r_ff;

    // reference oscillator: phase accumulator, reset on request
    nxt_r.ph = phase_reset_i ? srd_pkg::PH_RST : r_ff.ph + osc_freq_i;
    osc_c    = srd_pkg::sin_f(r_ff.ph[srd_pkg::PH_W-1 -: 6] + 6'h10);
    osc_s    = srd_pkg::sin_f(r_ff.ph[srd_pkg::PH_W-1 -: 6]);
    // output frequency, center offset only on the rf path
    nxt_r.fout = path_lf_i ? osc_freq_i : center_freq_i + osc_freq_i;

    // envelope: memory sample while a pulse plays, unity when continuous
    en_i = srd_pkg::ONE_Q15;
    en_q = '0;
    if (pulsed_i) begin
      en_i = r_ff.pact ? env_i_i : '0;
      en_q = r_ff.pact ? env_q_i : '0;
    end
    if (start_i && pulsed_i && !r_ff.busy) begin
      nxt_r.env_cnt = '0;
      nxt_r.pact    = (env_len_i != '0);
    end else if (r_ff.pact) begin
      nxt_r.env_cnt = r_ff.env_cnt + 1'b1;
      nxt_r.pact    = (r_ff.env_cnt + 1'b1) < env_len_i;
    end

    // reference = envelope times oscillator, shared by both paths
    nxt_r.ref_i = srd_pkg::mul_q15(en_i, osc_c) - srd_pkg::mul_q15(en_q, osc_s);
    nxt_r.ref_q = srd_pkg::mul_q15(en_i, osc_s) + srd_pkg::mul_q15(en_q, osc_c);
    // dac feed scaled by gain factor and output range
    amp         = srd_pkg::mul_q15(osc_gain_i, out_range_i);
    nxt_r.dac_i = srd_pkg::mul_q15(r_ff.ref_i, amp);
    nxt_r.dac_q = srd_pkg::mul_q15(r_ff.ref_q, amp);

    // second down-conversion oscillator, rf or lf word
    nxt_r.lo2_ph = r_ff.lo2_ph + (path_lf_i ? srd_pkg::LO2_LF_WORD : srd_pkg::LO2_RF_WORD);
    lo_c         = srd_pkg::sin_f(r_ff.lo2_ph[srd_pkg::PH_W-1 -: 6] + 6'h10);
    lo_s         = srd_pkg::sin_f(r_ff.lo2_ph[srd_pkg::PH_W-1 -: 6]);
    mx_i         = srd_pkg::mul_q15(adc_i, lo_c);
    mx_q         = -srd_pkg::mul_q15(adc_i, lo_s);
    // zero-frequency mixing on lf leaves the real sample unscaled
    if (path_lf_i) begin
      mx_i = adc_i;
      mx_q = '0;
    end

    // moving-average low-pass drops the sum-frequency image
    nxt_r.tap_i = {r_ff.tap_i[srd_pkg::LPF_TAPS-2:0], mx_i};
    nxt_r.tap_q = {r_ff.tap_q[srd_pkg::LPF_TAPS-2:0], mx_q};
    sum_i = '0;
    sum_q = '0;
    for (int k = 0; k < srd_pkg::LPF_TAPS; k++) begin
      sum_i = sum_i + LW'($signed(r_ff.tap_i[k]));
      sum_q = sum_q + LW'($signed(r_ff.tap_q[k]));
    end
    nxt_r.bb_i = sum_i[LW-1:srd_pkg::LPF_SH];
    nxt_r.bb_q = sum_q[LW-1:srd_pkg::LPF_SH];

    // scope tap scaling per path
    nxt_r.scp_i = srd_pkg::scl_f(r_ff.bb_i, path_lf_i ? srd_pkg::SCL_LF : srd_pkg::SCL_RF);
    nxt_r.scp_q = srd_pkg::scl_f(r_ff.bb_q, path_lf_i ? srd_pkg::SCL_LF : srd_pkg::SCL_RF);

    // baseband times conjugate reference
    pr_i = r_ff.bb_i * r_ff.ref_i + r_ff.bb_q * r_ff.ref_q;
    pr_q = r_ff.bb_q * r_ff.ref_i - r_ff.bb_i * r_ff.ref_q;

    // integration, division and result hand-off
    unique case (r_ff.st)
      srd_pkg::SRD_IDLE: begin
        if (start_i && int_len_i != '0) begin
          nxt_r.st    = srd_pkg::SRD_INTEG;
          nxt_r.busy  = 1'b1;
          nxt_r.acc_i = '0;
          nxt_r.acc_q = '0;
          nxt_r.cnt   = int_len_i;
          nxt_r.nlen  = int_len_i;
        end
      end
      srd_pkg::SRD_INTEG: begin
        // accumulate exactly n products
        nxt_r.acc_i = r_ff.acc_i + ACC_W'(pr_i);
        nxt_r.acc_q = r_ff.acc_q + ACC_W'(pr_q);
        nxt_r.cnt   = r_ff.cnt - 1'b1;
        if (r_ff.cnt == N_W'(1)) begin
          nxt_r.st = srd_pkg::SRD_DIV;
        end
      end
      srd_pkg::SRD_DIV: begin
        // bit-serial divide of the magnitudes by n
        if (r_ff.dcnt == srd_pkg::DIV_CNT_RST) begin
          nxt_r.qt_i = mag_f(r_ff.acc_i);
          nxt_r.qt_q = mag_f(r_ff.acc_q);
          nxt_r.sg_i = r_ff.acc_i[ACC_W-1];
          nxt_r.sg_q = r_ff.acc_q[ACC_W-1];
          nxt_r.rm_i = '0;
          nxt_r.rm_q = '0;
          nxt_r.dcnt = 6'h01;
        end else begin
          st_i       = div_step(r_ff.rm_i, r_ff.qt_i, r_ff.nlen);
          st_q       = div_step(r_ff.rm_q, r_ff.qt_q, r_ff.nlen);
          {nxt_r.rm_i, nxt_r.qt_i} = st_i;
          {nxt_r.rm_q, nxt_r.qt_q} = st_q;
          nxt_r.dcnt = r_ff.dcnt + 1'b1;
          if (r_ff.dcnt == 6'(ACC_W)) begin
            nxt_r.st   = srd_pkg::SRD_PUSH;
            nxt_r.dcnt = srd_pkg::DIV_CNT_RST;
            // rms scaling before the host sees the result
            nxt_r.res  = {rms_f(st_q[ACC_W-1:0], r_ff.sg_q), rms_f(st_i[ACC_W-1:0], r_ff.sg_i)};
          end
        end
      end
      srd_pkg::SRD_PUSH: begin
        // wait here while the result fifo is full
        if (fifo_ready) begin
          nxt_r.st   = srd_pkg::SRD_IDLE;
          nxt_r.busy = 1'b0;
        end
      end
    endcase
  end

  // state register, frozen while the clock enable is low
  // reset acts whatever the clock enable, so a frozen block still clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff        <= '0;
      r_ff.st     <= srd_pkg::SRD_IDLE;
      r_ff.ph     <= srd_pkg::PH_RST;
      r_ff.lo2_ph <= srd_pkg::PH_RST;
    end else if (ce_i) begin
      r_ff <= nxt_r;
    end
  end

  // result queue towards the host
  // its output register holds one word beyond the depth: nine results can wait
  srd_fifo #(
    .W     (2*srd_pkg::RES_W),
    .DEPTH (srd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (r_ff.st == srd_pkg::SRD_PUSH),
    .in_ready_o  (fifo_ready),
    .in_data_i   (r_ff.res),
    .out_valid_o (res_valid_o),
    .out_ready_i (res_ready_i),
    .out_data_o  (res_data_o)
  );

  // outputs straight from the state register
  assign env_addr_o = r_ff.env_cnt[ENV_AW-1:0];
  assign dac_i_o    = r_ff.dac_i;
  assign dac_q_o    = r_ff.dac_q;
  assign out_freq_o = r_ff.fout;
  assign scope_i_o  = r_ff.scp_i;
  assign scope_q_o  = r_ff.scp_q;
  assign busy_o     = r_ff.busy;
endmodule
`default_nettype wire

// file: tb/srd_top_props.sv
/*
  port checker of the readout datapath top.
  assumes one clock, synchronous active-high reset; bound to srd_top.
*/
`timescale 1ns/1ps
`default_nettype none
module srd_top_props #(
  parameter int ENV_AW = 15,
  parameter int N_W    = 22
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire logic              pulsed_i,
  input wire logic              path_lf_i,
  input wire logic [31:0]       osc_freq_i,
  input wire logic [31:0]       center_freq_i,
  input wire logic signed [15:0] osc_gain_i,
  input wire logic signed [15:0] out_range_i,
  input wire logic [ENV_AW:0]   env_len_i,
  input wire logic [N_W-1:0]    int_len_i,
  input wire logic              start_i,
  input wire logic              res_ready_i,
  input wire logic [ENV_AW-1:0] env_addr_o,
  input wire logic signed [15:0] dac_i_o,
  input wire logic signed [15:0] dac_q_o,
  input wire logic [31:0]       out_freq_o,
  input wire logic              busy_o,
  input wire logic              res_valid_o,
  input wire logic [63:0]       res_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a start that the block may take
  logic go;
  assign go = ce_i && start_i && !busy_o;

  chk_busy_hold: assert property (go && int_len_i != '0 |=> busy_o [*8])
    else $error("busy not held after start");
  chk_zero_len: assert property (go && int_len_i == '0 |=> !busy_o)
    else $error("start with zero count was taken");
  chk_busy_cause: assert property ($rose(busy_o) |-> $past(go))
    else $error("busy rose without a start");
  chk_freq_lf: assert property (ce_i && path_lf_i |=> out_freq_o == $past(osc_freq_i))
    else $error("lf output frequency carries an offset");
  chk_freq_rf: assert property (ce_i && !path_lf_i |=>
    out_freq_o == $past(osc_freq_i) + $past(center_freq_i))
    else $error("rf output frequency wrong");
  chk_res_hold: assert property (res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
    else $error("result dropped while host stalled");
  chk_env_walk: assert property (go && int_len_i != '0 && pulsed_i && env_len_i > 1 |=>
    env_addr_o == '0 ##1 env_addr_o == ENV_AW'(1))
    else $error("envelope address does not step");
  chk_dac_mute: assert property ((osc_gain_i == '0 || out_range_i == '0) && ce_i [*4] |->
    dac_i_o == '0 && dac_q_o == '0)
    else $error("dac not silent at zero gain");
endmodule
bind srd_top srd_top_props #(.ENV_AW(ENV_AW), .N_W(N_W)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pulsed_i(pulsed_i), .path_lf_i(path_lf_i),
  .osc_freq_i(osc_freq_i), .center_freq_i(center_freq_i), .osc_gain_i(osc_gain_i),
  .out_range_i(out_range_i), .env_len_i(env_len_i), .int_len_i(int_len_i), .start_i(start_i),
  .res_ready_i(res_ready_i), .env_addr_o(env_addr_o), .dac_i_o(dac_i_o), .dac_q_o(dac_q_o),
  .out_freq_o(out_freq_o), .busy_o(busy_o), .res_valid_o(res_valid_o), .res_data_o(res_data_o));
`default_nettype wire

// file: tb/srd_fe_model.sv
/*
  front end model: adc source and envelope memory.
  assumes the datapath clock; memory answers one cycle after the address.
*/
`timescale 1ns/1ps
`default_nettype none
module srd_fe_model #(
  parameter int AW = 15
) (
  input wire logic               clk_i,
  input wire logic               loop_i,
  input wire logic signed [15:0] level_i,
  input wire logic signed [15:0] dac_i_i,
  input wire logic [AW-1:0]      addr_i,
  output logic signed [15:0]     adc_o,
  output logic signed [15:0]     env_i_o,
  output logic signed [15:0]     env_q_o
);
  // adc sees a dc level or the dac wave looped back; envelope ramps with address
  always_ff @(posedge clk_i) begin
    adc_o   <= loop_i ? dac_i_i : level_i;
    env_i_o <= 16'sh2000 + 16'(addr_i);
    env_q_o <= 16'sh1000;
  end
endmodule
`default_nettype wire

// file: tb/srd_top_bench.sv
/*
  self-checking bench of the readout datapath top.
  assumes srd_pkg, srd_top, srd_fe_model and the checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module srd_top_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, pulsed_i = 1'b0, path_lf_i = 1'b0;
  logic phase_reset_i = 1'b0, start_i = 1'b0, res_ready_i = 1'b1, loop = 1'b0, ce_i = 1'b1;
  logic [31:0] osc_freq_i = '0, center_freq_i = '0, out_freq_o;
  logic signed [15:0] osc_gain_i = 16'sh7fff, out_range_i = 16'sh7fff, level = '0;
  logic signed [15:0] adc_i, env_i_i, env_q_i, dac_i_o, dac_q_o, scope_i_o, scope_q_o;
  logic [15:0] env_len_i = '0;
  logic [21:0] int_len_i = '0;
  logic [14:0] env_addr_o;
  logic        busy_o, res_valid_o;
  logic [63:0] res_data_o, ra, rb;
  int          err_count = 0, cmp_count = 0;

  // 200 mhz sample clock
  always #2.5 clk_i = ~clk_i;

  srd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pulsed_i(pulsed_i), .path_lf_i(path_lf_i),
    .osc_freq_i(osc_freq_i), .center_freq_i(center_freq_i), .phase_reset_i(phase_reset_i),
    .osc_gain_i(osc_gain_i), .out_range_i(out_range_i), .env_len_i(env_len_i), .int_len_i(int_len_i),
    .start_i(start_i), .env_i_i(env_i_i), .env_q_i(env_q_i), .adc_i(adc_i), .res_ready_i(res_ready_i),
    .env_addr_o(env_addr_o), .dac_i_o(dac_i_o), .dac_q_o(dac_q_o), .out_freq_o(out_freq_o),
    .scope_i_o(scope_i_o), .scope_q_o(scope_q_o), .busy_o(busy_o), .res_valid_o(res_valid_o),
    .res_data_o(res_data_o));

  srd_fe_model fe_u (.clk_i(clk_i), .loop_i(loop), .level_i(level), .dac_i_i(dac_i_o),
    .addr_i(env_addr_o), .adc_o(adc_i), .env_i_o(env_i_i), .env_q_o(env_q_i));

  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // one-cycle start with sample count n; returns at the negedge after the taking edge
  task automatic start_int(input logic [21:0] n);
    int_len_i = n;
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
  endtask

  // waits boundedly for one result word
  task automatic wait_res(output logic [63:0] r);
    int k;
    for (k = 0; k < 400 && res_valid_o !== 1'b1; k++) tick(1);
    chk({63'b0, res_valid_o}, 64'h1);
    r = res_data_o;
    tick(1);
  endtask

  task automatic t_freq;
    osc_freq_i = 32'h0123_4567;
    center_freq_i = 32'h1000_0000;
    tick(3);
    chk(out_freq_o, 32'h1123_4567);
    path_lf_i = 1'b1;
    tick(3);
    chk(out_freq_o, 32'h0123_4567);
    // a low clock enable freezes the output word until it returns
    ce_i = 1'b0;
    osc_freq_i = 32'h0765_4321;
    tick(3);
    chk(out_freq_o, 32'h0123_4567);
    ce_i = 1'b1;
    tick(1);
    chk(out_freq_o, 32'h0765_4321);
    $display("test freq done");
  endtask

  task automatic t_scope;
    logic signed [31:0] p;
    osc_freq_i = '0;
    level = 16'sh2000;
    tick(20);
    chk(64'(scope_i_o), 64'(16'sh2000));
    chk(64'(scope_q_o), 64'h0);
    path_lf_i = 1'b0;
    tick(20);
    p = (32'sh2000 * 32'sh7fd8) >>> 15;
    p = (p * 32'sh16a1) >>> 12;
    chk(64'(scope_i_o), 64'(p[15:0]));
    // quadrature arm: minus sine of phase zero, then root-two scaling
    p = -((32'sh2000 * 32'sh0647) >>> 15);
    p = (p * 32'sh16a1) >>> 12;
    chk(64'(scope_q_o), 64'(p));
    $display("test scope done");
  endtask

  task automatic t_dac;
    int k;
    logic seen;
    osc_freq_i = 32'h0400_0000;
    seen = 1'b0;
    repeat (64) begin tick(1); seen |= (dac_i_o != 0); end
    chk({63'b0, seen}, 64'h1);
    for (k = 0; k < 2; k++) begin
      osc_gain_i = k ? 16'sh7fff : 16'sh0000;
      out_range_i = k ? 16'sh0000 : 16'sh7fff;
      tick(6);
      seen = 1'b0;
      repeat (16) begin tick(1); seen |= ((dac_i_o | dac_q_o) != 0); end
      chk({63'b0, seen}, 64'h0);
    end
    out_range_i = 16'sh7fff;
    $display("test dac done");
  endtask

  task automatic t_env;
    int k;
    level = '0;
    pulsed_i = 1'b1;
    env_len_i = 16'h0005;
    tick(10);
    start_int(22'h8);
    for (k = 0; k < 5; k++) begin chk(64'(env_addr_o), 64'(k)); tick(1); end
    wait_res(ra);
    chk(ra, 64'h0);
    pulsed_i = 1'b0;
    $display("test envelope done");
  endtask

  task automatic t_norm;
    level = 16'sh2000;
    osc_freq_i = '0;
    phase_reset_i = 1'b1;
    tick(20);
    phase_reset_i = 1'b0;
    start_int(22'h4);
    wait_res(ra);
    start_int(22'h8);
    wait_res(rb);
    chk(rb, ra);
    chk({63'b0, ra !== '0}, 64'h1);
    level = '0;
    tick(10);
    start_int(22'h3);
    wait_res(ra);
    chk(ra, 64'h0);
    $display("test normalise done");
  endtask

  task automatic t_refuse;
    int n;
    start_int(22'h0);
    tick(3);
    chk({63'b0, busy_o}, 64'h0);
    start_int(22'h4);
    tick(2);
    start_int(22'h4);
    wait_res(ra);
    n = 0;
    repeat (100) begin n += res_valid_o; tick(1); end
    chk(64'(n), 64'h0);
    $display("test refuse done");
  endtask

  task automatic t_phase;
    int k;
    logic [63:0] rr [2];
    loop = 1'b1;
    osc_freq_i = 32'h0200_0000;
    for (k = 0; k < 2; k++) begin
      phase_reset_i = 1'b1;
      tick(40);
      phase_reset_i = 1'b0;
      start_int(22'h10);
      wait_res(rr[k]);
    end
    chk(rr[1], rr[0]);
    chk({63'b0, rr[0] !== '0}, 64'h1);
    loop = 1'b0;
    $display("test phase done");
  endtask

  task automatic t_fifo;
    int k, n;
    res_ready_i = 1'b0;
    // nine results fill the fifo and its output register; the tenth stalls
    for (k = 0; k < 9; k++) begin
      start_int(22'h2);
      for (n = 0; n < 200 && busy_o !== 1'b0; n++) tick(1);
    end
    start_int(22'h2);
    tick(100);
    chk({63'b0, busy_o}, 64'h1);
    res_ready_i = 1'b1;
    n = 0;
    repeat (300) begin if (res_valid_o === 1'b1) n++; tick(1); end
    chk(64'(n), 64'ha);
    chk({63'b0, busy_o}, 64'h0);
    $display("test fifo done");
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    tick(16);
    chk({62'b0, busy_o, res_valid_o}, 64'h0);
    chk(res_data_o, 64'h0);
    rst_i = 1'b0;
    t_freq();
    t_scope();
    t_dac();
    t_env();
    t_norm();
    t_refuse();
    t_phase();
    t_fifo();
    stop_test();
  end

  // watchdog: all tests take a few thousand cycles
  initial begin
    #200000;
    err_count++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
`default_nettype wire
